// ==== rtl/power_supervisor_reset_logic.sv ====
// Behaviour
// RULE1: direct mode switches on vdd below vbat
// RULE2: switch-over off: flag zero, main supply
// RULE3: battery-low flag follows comparator, also on battery
// RULE4: battery-low interrupt only when enabled
// RULE5: software cannot clear battery-low flag
// RULE6: power-fail low while input below reference
// RULE7: on battery, comparator off, output low
// RULE8: after return, release for recovery time
// RULE9: switch-over off: output follows comparator only
// RULE10: oscillator stop forces reset, sets flag
// RULE11: reset pin low until oscillator stable
// RULE12: oscillator flag stays until host clears
// RULE13: reset held while oscillator counts stopped
// RULE14: reset defaults clock out, arm, 24h, all on (the code resets the arm bit to 0)
// RULE15: arm bit plus pin pattern enters override
// RULE16: override releases reset immediately
// RULE17: arm bit zero ends override mode
// RULE18: selector decodes mode and detect enables
// RULE19: battery switch sets flag, optional interrupt
// RULE20: battery switch flag cleared by command
// RULE21: on battery, interface ignored, outputs released
// RULE22: override pattern is parameterised sequence
// RULE23: interrupt while any enabled flag set
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module power_supervisor_reset_logic (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic vdd_lt_vbat, // Comparator: main below battery
   input wire logic vdd_lt_vth, // Comparator: main below switch threshold
   input wire logic vbat_low, // Comparator: battery below low threshold
   input wire logic power_fail_in, // Comparator: input below 1.25 V
   input wire logic osc_ok, // Oscillator running and stable
   input wire logic scl_in, // Serial clock pin
   input wire logic sda_in, // Serial data pin
   input wire logic host_sda_out, // Serial engine data out
   input wire logic host_sda_oe, // Serial engine data enable
   output logic sda_out, // Serial data pin drive level
   output logic sda_oe, // Serial data pin enable
   output logic host_sda_in, // Serial data gated to engine
   output logic host_scl_in, // Serial clock gated to engine
   output logic backed_supply_out, // High while running on battery
   output logic power_fail_out_n, // Power-fail open-drain level
   output logic power_fail_oe, // Power-fail pin enable
   output logic reset_out_n, // Reset open-drain level
   output logic reset_oe, // Reset pin enable
   output logic irq_out_n, // Interrupt open-drain level
   output logic irq_oe, // Interrupt pin enable
   output logic square_wave_en, // 32.768 kHz output enable
   output logic mode_24h // Hour mode select
);

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   function automatic supervisor_pkg::pm_cfg_t decode_sel(input logic [2:0] sel);
      supervisor_pkg::pm_cfg_t c;
      c.mode = supervisor_pkg::SW_OFF;
      c.low_det_en = 1'b0;
      c.pf_det_en = 1'b0;
      case (sel)
         3'h0: c = '{supervisor_pkg::SW_STANDARD, 1'b1, 1'b1};
         3'h1: c = '{supervisor_pkg::SW_STANDARD, 1'b0, 1'b1};
         3'h2: c = '{supervisor_pkg::SW_STANDARD, 1'b0, 1'b0};
         3'h3: c = '{supervisor_pkg::SW_DIRECT, 1'b1, 1'b1};
         3'h4: c = '{supervisor_pkg::SW_DIRECT, 1'b0, 1'b1};
         3'h5: c = '{supervisor_pkg::SW_DIRECT, 1'b0, 1'b0};
         3'h6: c = '{supervisor_pkg::SW_OFF, 1'b0, 1'b1};
         default: c = '{supervisor_pkg::SW_OFF, 1'b0, 1'b0};
      endcase
      return c;
   endfunction

   logic [7:0] ctrl_q;
   logic flag_bsf_q, flag_blf_q, flag_osf_q;
   logic on_bat_q, ovr_q, rst_q;
   logic [$clog2(supervisor_pkg::TREC_CYC+1)-1:0] rec_cnt_q;
   logic [1:0] seq_idx_q;
   logic [1:0] last_pins_q;

   wire supervisor_pkg::pm_cfg_t cfg =
      decode_sel(ctrl_q[supervisor_pkg::SEL_LSB +: 3]); // see RULE18
   wire arm = ctrl_q[supervisor_pkg::ARM_BIT];

   // Supply choice: direct ignores the threshold comparator
   wire on_bat_d = (cfg.mode == supervisor_pkg::SW_DIRECT) ? vdd_lt_vbat : // see RULE1
                   (cfg.mode == supervisor_pkg::SW_STANDARD) ? (vdd_lt_vbat && vdd_lt_vth) :
                   1'b0; // see RULE2
   wire bat_entry = on_bat_d && !on_bat_q;
   wire bat_exit = !on_bat_d && on_bat_q;

   // -----------------------------------------------------------------
   // AXI4-Lite slave
   // -----------------------------------------------------------------
   logic aw_hold_q, w_hold_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire aw_have = aw_hold_q || aw_take;
   wire w_have = w_hold_q || w_take;
   wire [7:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr[7:0];
   wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
   wire [3:0] wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
   wire wr_fire = aw_have && w_have && !s_axi_bvalid;
   wire wr_hit = wr_addr == supervisor_pkg::CTRL_OFS || wr_addr == supervisor_pkg::CMD_OFS;
   wire ctrl_wr = wr_fire && wr_addr == supervisor_pkg::CTRL_OFS && wr_strb[0];
   wire cmd_wr = wr_fire && wr_addr == supervisor_pkg::CMD_OFS && wr_strb[0];
   wire clr_bsf = cmd_wr && wr_data[supervisor_pkg::CLR_BSF_BIT]; // see RULE20
   wire clr_osf = cmd_wr && wr_data[supervisor_pkg::CLR_OSF_BIT]; // see RULE12

   wire [7:0] status = {!irq_out_n, power_fail_out_n, rst_q, ovr_q, on_bat_q,
                        flag_osf_q, flag_blf_q, flag_bsf_q};
   wire [7:0] rd_addr = s_axi_araddr[7:0];
   wire rd_hit = rd_addr == supervisor_pkg::CTRL_OFS || rd_addr == supervisor_pkg::STAT_OFS
      || rd_addr == supervisor_pkg::CMD_OFS || rd_addr == supervisor_pkg::LINE_OFS;
   wire [7:0] rd_val = (rd_addr == supervisor_pkg::CTRL_OFS) ? ctrl_q :
                       (rd_addr == supervisor_pkg::STAT_OFS) ? status :
                       (rd_addr == supervisor_pkg::LINE_OFS) ?
                       {2'h0, osc_ok, power_fail_in, vbat_low, vdd_lt_vth, vdd_lt_vbat,
                        on_bat_d} : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !aw_have && !s_axi_bvalid && !wr_fire;
         s_axi_wready <= !w_have && !s_axi_bvalid && !wr_fire;
         if (aw_take) aw_addr_q <= s_axi_awaddr[7:0];
         if (w_take) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         aw_hold_q <= aw_have && !wr_fire;
         w_hold_q <= w_have && !wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Control and flags
   // -----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= supervisor_pkg::CTRL_RST; // see RULE14
      end else if (ctrl_wr) begin
         ctrl_q <= wr_data[7:0];
      end
   end

   // Event set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_bat_q <= 1'b0;
         flag_bsf_q <= 1'b0;
         flag_blf_q <= 1'b0;
      end else begin
         on_bat_q <= on_bat_d;
         if (cfg.mode == supervisor_pkg::SW_OFF) flag_bsf_q <= 1'b0; // see RULE2
         else if (bat_entry) flag_bsf_q <= 1'b1; // see RULE19
         else if (clr_bsf) flag_bsf_q <= 1'b0; // see RULE20
         // No software path clears this flag
         flag_blf_q <= cfg.low_det_en && vbat_low; // see RULE3 RULE5
      end
   end

   // -----------------------------------------------------------------
   // Power-fail output and recovery
   // -----------------------------------------------------------------
   wire rec_busy = rec_cnt_q != '0;
   wire pf_low = cfg.pf_det_en && !on_bat_q && !rec_busy && power_fail_in; // see RULE6 RULE9
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rec_cnt_q <= '0;
         power_fail_out_n <= 1'b1;
         power_fail_oe <= 1'b0;
      end else begin
         if (on_bat_d) rec_cnt_q <= '0;
         else if (bat_exit) rec_cnt_q <= ($bits(rec_cnt_q))'(supervisor_pkg::TREC_CYC); // see RULE8
         else if (rec_busy) rec_cnt_q <= rec_cnt_q - 1'b1;
         // On battery the comparator is ignored and the pin is pulled low
         power_fail_out_n <= !(on_bat_d || pf_low); // see RULE7
         power_fail_oe <= on_bat_d || pf_low;
      end
   end

   // -----------------------------------------------------------------
   // Reset, oscillator flag and override
   // -----------------------------------------------------------------
   // Pattern detector: each step is a (sda, scl) level that must appear in order
   wire [1:0] pins = {sda_in, scl_in};
   wire [1:0] seq_want = (seq_idx_q == 2'h0) ? supervisor_pkg::OVR_SEQ0 :
                         (seq_idx_q == 2'h1) ? supervisor_pkg::OVR_SEQ1 :
                         (seq_idx_q == 2'h2) ? supervisor_pkg::OVR_SEQ2 :
                         supervisor_pkg::OVR_SEQ3;
   wire seq_step = pins != last_pins_q && pins == seq_want;
   wire seq_done = seq_step && seq_idx_q == 2'(supervisor_pkg::OVR_SEQ_LEN - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_idx_q <= 2'h0;
         last_pins_q <= 2'h3;
         ovr_q <= 1'b0;
         rst_q <= 1'b1;
         flag_osf_q <= 1'b1;
      end else begin
         last_pins_q <= pins;
         if (!arm || ovr_q) seq_idx_q <= 2'h0;
         else if (seq_step) seq_idx_q <= seq_idx_q + 2'h1; // see RULE22
         else if (pins != last_pins_q) seq_idx_q <= 2'h0;
         if (!arm) ovr_q <= 1'b0; // see RULE17
         else if (seq_done) ovr_q <= 1'b1; // see RULE15
         // Override drops reset at once; else reset follows the oscillator
         rst_q <= !(ovr_q || seq_done) && !osc_ok; // see RULE10 RULE11 RULE13 RULE16
         if (!osc_ok && !(ovr_q || seq_done)) flag_osf_q <= 1'b1; // see RULE10 RULE13
         else if (clr_osf) flag_osf_q <= 1'b0; // see RULE12
      end
   end

   // -----------------------------------------------------------------
   // Pins
   // -----------------------------------------------------------------
   wire irq_d = (flag_bsf_q && ctrl_q[supervisor_pkg::BSIE_BIT]) || // see RULE19 RULE23
                (flag_blf_q && ctrl_q[supervisor_pkg::BATTERY_LOW_IRQ_EN_BIT]); // see RULE4
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_out_n <= 1'b0;
         reset_oe <= 1'b1;
         irq_out_n <= 1'b1;
         irq_oe <= 1'b0;
         sda_out <= 1'b1;
         sda_oe <= 1'b0;
         host_sda_in <= 1'b1;
         host_scl_in <= 1'b1;
         backed_supply_out <= 1'b0;
         square_wave_en <= 1'b1;
         mode_24h <= 1'b1;
      end else begin
         reset_out_n <= !rst_q; // see RULE11
         reset_oe <= rst_q;
         irq_out_n <= !irq_d; // see RULE23
         irq_oe <= irq_d;
         // Battery operation cuts the serial interface both ways
         sda_out <= host_sda_out;
         sda_oe <= host_sda_oe && !on_bat_d; // see RULE21
         host_sda_in <= on_bat_d ? 1'b1 : sda_in; // see RULE21
         host_scl_in <= on_bat_d ? 1'b1 : scl_in;
         backed_supply_out <= on_bat_d;
         square_wave_en <= ctrl_q[supervisor_pkg::CLKEN_BIT];
         mode_24h <= ctrl_q[supervisor_pkg::H24_BIT];
      end
   end

endmodule
`default_nettype wire

// ==== rtl/supervisor_pkg.sv ====
package supervisor_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] CMD_OFS = 8'h08;
   localparam logic [7:0] LINE_OFS = 8'h0c;

   // Control word bits
   localparam int SEL_LSB = 0;
   localparam int BSIE_BIT = 3;
   localparam int BATTERY_LOW_IRQ_EN_BIT = 4;
   localparam int ARM_BIT = 5;
   localparam int CLKEN_BIT = 6;
   localparam int H24_BIT = 7;

   // Status word bits
   localparam int BSF_BIT = 0;
   localparam int BLF_BIT = 1;
   localparam int OSF_BIT = 2;
   localparam int ONBAT_BIT = 3;
   localparam int OVR_BIT = 4;
   localparam int RST_BIT = 5;
   localparam int PFO_BIT = 6;
   localparam int IRQ_BIT = 7;

   // Write-one-to-clear command bits
   localparam int CLR_BSF_BIT = 0;
   localparam int CLR_OSF_BIT = 2;

   // Reset value of the control word: selector 000, clock out, arm off, 24 h
   localparam logic [7:0] CTRL_RST = 8'hc0;
   localparam logic [2:0] SEL_RST = 3'h0;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam real TREC_MIN_MS = 15.63;
   localparam real TREC_MAX_MS = 31.25;
   // Aim at the middle of the recovery window
   localparam int TREC_CYC = int'((TREC_MIN_MS + TREC_MAX_MS) / 2.0 * CLK_HZ / 1000.0);
   localparam int OVR_SEQ_LEN = 4;
   localparam logic [1:0] OVR_SEQ0 = 2'h3;
   localparam logic [1:0] OVR_SEQ1 = 2'h1;
   localparam logic [1:0] OVR_SEQ2 = 2'h0;
   localparam logic [1:0] OVR_SEQ3 = 2'h2;

   typedef enum logic [1:0] {
      SW_STANDARD,
      SW_DIRECT,
      SW_OFF
   } sw_mode_t;

   typedef struct packed {
      sw_mode_t mode;
      logic low_det_en;
      logic pf_det_en;
   } pm_cfg_t;

   typedef struct packed {
      logic vdd_lt_vbat;
      logic vdd_lt_vth;
      logic vbat_low;
      logic pfi_low;
   } cmp_t;

   typedef struct packed {
      logic sda_out;
      logic sda_oe;
      logic irq_n;
      logic rst_n;
      logic pfo_n;
      logic bbs_on_bat;
   } pins_t;

endpackage

// ==== bench/power_supervisor_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module power_supervisor_chk (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic vdd_lt_vbat, // Main below battery
   input wire logic osc_ok, // Oscillator stable
   input wire logic backed_supply_out, // On battery
   input wire logic sda_oe, // Data pin enable
   input wire logic host_sda_in, // Data to engine
   input wire logic host_scl_in, // Clock to engine
   input wire logic power_fail_out_n, // Power-fail level
   input wire logic power_fail_oe, // Power-fail enable
   input wire logic reset_out_n, // Reset level
   input wire logic irq_out_n, // Interrupt level
   input wire logic irq_oe, // Interrupt enable
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   input wire logic [31:0] s_axi_rdata // Read data
);
   // ----------------------------------------------
   // Port relations
   // ----------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // One cycle of margin: pin gating may trail the supply flop
   sequence on_bat2;
      backed_supply_out && $past(backed_supply_out);
   endsequence
   sequence osc_run;
      osc_ok [*4];
   endsequence
   chk_bat_iface: assert property (on_bat2 |-> !sda_oe && host_sda_in && host_scl_in)
      else $error("serial interface active on battery");
   chk_bat_pfo: assert property (on_bat2 |-> power_fail_oe)
      else $error("power-fail not low on battery");
   chk_main_only: assert property (!vdd_lt_vbat [*4] |-> !backed_supply_out)
      else $error("battery chosen with main above battery");
   chk_osc_loss: assert property ($fell(osc_ok) |-> ##[1:4] !reset_out_n)
      else $error("no reset after oscillator stop");
   chk_rst_release: assert property (osc_run |-> reset_out_n)
      else $error("reset held with oscillator stable");
   chk_pfo_pull: assert property (power_fail_oe |-> !power_fail_out_n)
      else $error("power-fail enabled but not low");
   chk_irq_pull: assert property (irq_oe |-> !irq_out_n)
      else $error("interrupt enabled but not low");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule
bind power_supervisor_reset_logic power_supervisor_chk power_supervisor_chk_i (
   .aclk(aclk), .aresetn(aresetn), .vdd_lt_vbat(vdd_lt_vbat), .osc_ok(osc_ok),
   .backed_supply_out(backed_supply_out), .sda_oe(sda_oe), .host_sda_in(host_sda_in),
   .host_scl_in(host_scl_in), .power_fail_out_n(power_fail_out_n),
   .power_fail_oe(power_fail_oe), .reset_out_n(reset_out_n), .irq_out_n(irq_out_n),
   .irq_oe(irq_oe), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// ==== bench/supply_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module supply_host_model (
   input wire logic aclk, // Clock
   input wire supervisor_pkg::cmp_t cmp_req, // Analog levels wanted
   input wire logic [1:0] pins_req, // Host drive of data, clock
   input wire logic sda_out, // Device data level
   input wire logic sda_oe, // Device data enable
   input wire logic pfo_oe, // Device power-fail enable
   output var supervisor_pkg::cmp_t cmp, // Comparator results
   output logic sda_wire, // Resolved data line
   output logic scl_wire, // Clock line
   output logic pfo_wire // Power-fail line
);
   // ----------------------------------------------
   // Comparators and pulled-up lines
   // ----------------------------------------------
   always_ff @(posedge aclk) begin
      cmp <= cmp_req;
   end
   // Host walks the entry pattern on these lines
   assign sda_wire = pins_req[1] & ~(sda_oe & ~sda_out);
   assign scl_wire = pins_req[0];
   assign pfo_wire = ~pfo_oe;
endmodule
`default_nettype wire

// ==== bench/power_supervisor_reset_logic_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module power_supervisor_reset_logic_test;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic osc_ok = 1'h0, host_sda_out = 1'h0, host_sda_oe = 1'h0;
   logic [1:0] pins_req = 2'h3, bresp, rresp, rs;
   supervisor_pkg::cmp_t cmp_req = 4'h0, cmp;
   logic awready, wready, bvalid, arready, rvalid, sda_out, sda_oe, hsda, hscl, bat;
   logic pfo_n, pfo_oe, rst_n, rst_oe, irq_n, irq_oe, sqw, m24, sda_w, scl_w, pfo_w;
   int error_cnt = 0;
   int n_tests = 0;
   power_supervisor_reset_logic power_supervisor_reset_logic_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .vdd_lt_vbat(cmp.vdd_lt_vbat), .vdd_lt_vth(cmp.vdd_lt_vth), .vbat_low(cmp.vbat_low),
      .power_fail_in(cmp.pfi_low), .osc_ok(osc_ok), .scl_in(scl_w), .sda_in(sda_w),
      .host_sda_out(host_sda_out), .host_sda_oe(host_sda_oe), .sda_out(sda_out),
      .sda_oe(sda_oe), .host_sda_in(hsda), .host_scl_in(hscl), .backed_supply_out(bat),
      .power_fail_out_n(pfo_n), .power_fail_oe(pfo_oe), .reset_out_n(rst_n),
      .reset_oe(rst_oe), .irq_out_n(irq_n), .irq_oe(irq_oe), .square_wave_en(sqw),
      .mode_24h(m24)
   );
   supply_host_model supply_host_model_i (
      .aclk(aclk), .cmp_req(cmp_req), .pins_req(pins_req), .sda_out(sda_out),
      .sda_oe(sda_oe), .pfo_oe(pfo_oe), .cmp(cmp), .sda_wire(sda_w), .scl_wire(scl_w),
      .pfo_wire(pfo_w)
   );
   // ----------------------------------------------
   // Bus cycles and helpers
   // ----------------------------------------------
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task cmp_v(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task drive(input logic [3:0] c);
      @(posedge aclk);
      cmp_req <= c;
      tick(5);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic aw, w;
      aw = 1'h0;
      w = 1'h0;
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(aw && w)) begin
         @(posedge aclk);
         aw = aw | (awvalid & awready);
         w = w | (wvalid & wready);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end
      bready <= 1'h1;
      do @(posedge aclk); while (bvalid !== 1'h1);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task rd_r(input logic [7:0] a);
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      rready <= 1'h1;
      do @(posedge aclk); while (rvalid !== 1'h1);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   // ----------------------------------------------
   // Scenarios
   // ----------------------------------------------
   task t_reset;
      rd_r(supervisor_pkg::STAT_OFS);
      cmp_v(rd & 32'h27, 32'h24, "status after reset");
      rd_r(supervisor_pkg::CTRL_OFS);
      cmp_v(rd, 32'hc0, "control after reset");
      cmp_v({sqw, m24, rst_n, rst_oe}, 32'hd, "reset pins");
      osc_ok <= 1'h1;
      tick(6);
      cmp_v(rst_n, 32'h1, "reset release");
      rd_r(supervisor_pkg::STAT_OFS);
      cmp_v(rd & 32'h4, 32'h4, "oscillator flag kept");
      wr(supervisor_pkg::CMD_OFS, 8'h04);
      rd_r(supervisor_pkg::STAT_OFS);
      cmp_v(rd & 32'h4, 32'h0, "oscillator flag clear");
      rd_r(8'h40);
      cmp_v(rs, 32'h2, "unmapped read");
      wr(8'h44, 8'h01);
      cmp_v(rs, 32'h2, "unmapped write");
   endtask
   task t_pfo;
      logic [2:0] sels [3] = '{3'h0, 3'h6, 3'h7};
      for (int i = 0; i < 3; i++) begin
         wr(supervisor_pkg::CTRL_OFS, {5'h18, sels[i]});
         drive(4'h1);
         cmp_v(pfo_oe, sels[i] != 3'h7, "power-fail follows input");
         cmp_v({pfo_n, pfo_w}, {2{sels[i] == 3'h7}}, "power-fail line level");
         drive(4'h0);
         cmp_v(pfo_oe, 32'h0, "power-fail released");
         cmp_v({pfo_n, pfo_w}, 32'h3, "power-fail line high");
      end
   endtask
   task t_modes;
      logic [2:0] s;
      logic battery_low_flag;
      host_sda_oe <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         s = 3'(i);
         battery_low_flag = (s == 3'h0) || (s == 3'h3);
         wr(supervisor_pkg::CTRL_OFS, {5'h18, s});
         drive(4'ha);
         cmp_v(bat, s >= 3'h3 && s <= 3'h5, "direct switching choice");
         drive(4'he);
         cmp_v(bat, s < 3'h6, "standard switching choice");
         cmp_v({sda_oe, hsda, hscl, pfo_oe}, {s >= 3'h6, s < 3'h6, 1'h1, s < 3'h6},
               "pins on battery");
         rd_r(supervisor_pkg::STAT_OFS);
         cmp_v(rd & 32'h3, {battery_low_flag, s < 3'h6}, "supply flags");
         wr(supervisor_pkg::CMD_OFS, 8'hff);
         rd_r(supervisor_pkg::STAT_OFS);
         cmp_v(rd & 32'h2, {battery_low_flag, 1'h0}, "low flag kept");
         drive(4'h1);
         cmp_v(bat, 32'h0, "back to main");
         if (s < 3'h6) cmp_v(pfo_oe, 32'h0, "recovery release");
         wr(supervisor_pkg::CMD_OFS, 8'h01);
         rd_r(supervisor_pkg::STAT_OFS);
         cmp_v(rd & 32'h1, 32'h0, "switch flag clear");
         drive(4'h0);
      end
      host_sda_oe <= 1'h0;
   endtask
   task t_irq;
      wr(supervisor_pkg::CTRL_OFS, 8'hd0);
      drive(4'h2);
      cmp_v({irq_oe, irq_n}, 32'h2, "low interrupt");
      wr(supervisor_pkg::CTRL_OFS, 8'hc0);
      tick(3);
      cmp_v(irq_oe, 32'h0, "low interrupt masked");
      drive(4'h0);
      rd_r(supervisor_pkg::STAT_OFS);
      cmp_v(rd & 32'h2, 32'h0, "low flag self clear");
      wr(supervisor_pkg::CTRL_OFS, 8'hc8);
      drive(4'hc);
      drive(4'h0);
      cmp_v(irq_oe, 32'h1, "switch interrupt");
      wr(supervisor_pkg::CMD_OFS, 8'h01);
      tick(3);
      cmp_v(irq_oe, 32'h0, "switch interrupt clear");
   endtask
   task pattern;
      logic [1:0] seq [5] = '{2'h0, supervisor_pkg::OVR_SEQ0, supervisor_pkg::OVR_SEQ1,
         supervisor_pkg::OVR_SEQ2, supervisor_pkg::OVR_SEQ3};
      for (int i = 0; i < 5; i++) begin
         pins_req <= seq[i];
         tick(3);
      end
   endtask
   task t_override;
      osc_ok <= 1'h0;
      tick(6);
      cmp_v(rst_n, 32'h0, "reset on oscillator stop");
      rd_r(supervisor_pkg::STAT_OFS);
      cmp_v(rd & 32'h4, 32'h4, "oscillator flag set");
      pattern();
      cmp_v(rst_n, 32'h0, "no override unarmed");
      wr(supervisor_pkg::CTRL_OFS, 8'he0);
      pattern();
      cmp_v(rst_n, 32'h1, "override releases reset");
      rd_r(supervisor_pkg::STAT_OFS);
      cmp_v(rd & 32'h10, 32'h10, "override status");
      wr(supervisor_pkg::CTRL_OFS, 8'hc0);
      tick(3);
      cmp_v(rst_n, 32'h0, "override ended");
   endtask
   initial begin
      forever #10 aclk = ~aclk;
   end
   // Whole run is well under a thousand cycles; this leaves a wide margin
   initial begin
      #200000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      tick(12);
      aresetn <= 1'h1;
      t_reset();
      t_pfo();
      t_modes();
      t_irq();
      t_override();
      give_verdict();
   end
endmodule
`default_nettype wire
